//--- hdl/dsoo_setpoint_objects.v
// set-point offset and interpolation objects of a drive controller
// assumes a fieldbus engine presents one-cycle object writes and reads,
// and a sync tick from the bus cycle, all synchronous to clk
`timescale 1ns/100ps
`include "dsoo_consts.vh"

// Contract
// - velocity unit word bits 8-15 hold time unit; bits 0-7 read zero
// - velocity unit word bits 16-23 hold position unit code
// - velocity unit word bits 24-31 hold power-of-ten exponent
// - position offset added to position set value only in csp mode
// - velocity offset added to speed set value in csp, csv, clkdir
// - torque offset added to torque set value in csp, cst, clkdir
// - interpolation set-point supplies demand position for ip mode
// - new interpolation set-point takes effect at next sync event
module dsoo_setpoint_objects (
   input  wire        clk,
   input  wire        arst_n,
   input  wire        clk_en,
   input  wire        obj_wr,
   input  wire        obj_rd,
   input  wire [15:0] obj_index,
   input  wire [31:0] obj_wdata,
   input  wire        sync_tick,
   input  wire [7:0]  op_mode,
   input  wire [31:0] pos_set_in,
   input  wire [31:0] vel_set_in,
   input  wire [15:0] trq_set_in,
   output reg  [31:0] obj_rdata_q,
   output reg         obj_ack_q,
   output reg         obj_err_q,
   output reg  [31:0] pos_set_out_q,
   output reg  [31:0] vel_set_out_q,
   output reg  [15:0] trq_set_out_q,
   output reg  [31:0] ip_demand_q,
   output reg         ip_demand_vld_q,
   output reg  [7:0]  vu_time_q,
   output reg  [7:0]  vu_pos_q,
   output reg  [7:0]  vu_exp_q
);

   // ====================================================================
   // object decoding
   function is_known;
      input [15:0] idx;
      begin
         is_known = (idx == `DSOO_IDX_VEL_UNIT) ||
                    (idx == `DSOO_IDX_POS_OFS)  ||
                    (idx == `DSOO_IDX_VEL_OFS)  ||
                    (idx == `DSOO_IDX_TRQ_OFS)  ||
                    (idx == `DSOO_IDX_IP_SETPT);
      end
   endfunction

   reg [31:0] vel_unit_q;
   reg [31:0] pos_ofs_q;
   reg [31:0] vel_ofs_q;
   reg [15:0] trq_ofs_q;
   reg [31:0] ip_pend_q;
   reg        ip_new_q;

   wire wr_vu  = obj_wr && (obj_index == `DSOO_IDX_VEL_UNIT);
   wire wr_po  = obj_wr && (obj_index == `DSOO_IDX_POS_OFS);
   wire wr_vo  = obj_wr && (obj_index == `DSOO_IDX_VEL_OFS);
   wire wr_to  = obj_wr && (obj_index == `DSOO_IDX_TRQ_OFS);
   wire wr_ip  = obj_wr && (obj_index == `DSOO_IDX_IP_SETPT);

   // ====================================================================
   // mode qualifiers
   wire m_csp = (op_mode == `DSOO_MODE_CSP);
   wire m_csv = (op_mode == `DSOO_MODE_CSV);
   wire m_cst = (op_mode == `DSOO_MODE_CST);
   wire m_cd  = (op_mode == `DSOO_MODE_CLKDIR);
   wire m_ip  = (op_mode == `DSOO_MODE_IP);

   // ====================================================================
   // object storage
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vel_unit_q <= `DSOO_RST_VEL_UNIT;
         pos_ofs_q  <= `DSOO_RST_POS_OFS;
         vel_ofs_q  <= `DSOO_RST_VEL_OFS;
         trq_ofs_q  <= `DSOO_RST_TRQ_OFS;
         ip_pend_q  <= `DSOO_RST_IP_SETPT;
         ip_new_q   <= 1'b0;
      end else if (clk_en) begin
         if (wr_vu) begin
            // low byte is reserved and always held at zero
            vel_unit_q <= obj_wdata & ~`DSOO_VU_RSVD_MASK;
         end
         if (wr_po) begin
            pos_ofs_q <= obj_wdata;
         end
         if (wr_vo) begin
            vel_ofs_q <= obj_wdata;
         end
         if (wr_to) begin
            trq_ofs_q <= obj_wdata[15:0];
         end
         // a write coinciding with sync stays pending for the next sync
         if (wr_ip) begin
            ip_pend_q <= obj_wdata;
            ip_new_q  <= 1'b1;
         end else if (sync_tick) begin
            ip_new_q  <= 1'b0;
         end
      end
   end

   // ====================================================================
   // unit fields presented to the scaling logic
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vu_time_q <= 8'h47;
         vu_pos_q  <= 8'hB4;
         vu_exp_q  <= 8'h00;
      end else if (clk_en) begin
         vu_time_q <= vel_unit_q[`DSOO_VU_TIME_MSB:`DSOO_VU_TIME_LSB];
         vu_pos_q  <= vel_unit_q[`DSOO_VU_POS_MSB:`DSOO_VU_POS_LSB];
         vu_exp_q  <= vel_unit_q[`DSOO_VU_EXP_MSB:`DSOO_VU_EXP_LSB];
      end
   end

   // ====================================================================
   // set-value offsetting, gated by the active mode
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_set_out_q <= 32'h00000000;
         vel_set_out_q <= 32'h00000000;
         trq_set_out_q <= 16'h0000;
      end else if (clk_en) begin
         pos_set_out_q <= m_csp ? pos_set_in + pos_ofs_q
                                : pos_set_in;
         vel_set_out_q <= (m_csp || m_csv || m_cd)
                          ? vel_set_in + vel_ofs_q
                          : vel_set_in;
         trq_set_out_q <= (m_csp || m_cst || m_cd)
                          ? trq_set_in + trq_ofs_q
                          : trq_set_in;
      end
   end

   // ====================================================================
   // interpolator demand, taken over only on a sync tick
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ip_demand_q     <= 32'h00000000;
         ip_demand_vld_q <= 1'b0;
      end else if (clk_en) begin
         if (sync_tick && ip_new_q) begin
            ip_demand_q <= ip_pend_q;
         end
         ip_demand_vld_q <= m_ip;
      end
   end

   // ====================================================================
   // object read and acknowledge
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         obj_rdata_q <= 32'h00000000;
         obj_ack_q   <= 1'b0;
         obj_err_q   <= 1'b0;
      end else if (clk_en) begin
         obj_ack_q <= (obj_wr || obj_rd) && is_known(obj_index);
         obj_err_q <= (obj_wr || obj_rd) && !is_known(obj_index);
         obj_rdata_q <= 32'h00000000;
         if (obj_rd) begin
            case (obj_index)
               `DSOO_IDX_VEL_UNIT: obj_rdata_q <= vel_unit_q;
               `DSOO_IDX_POS_OFS:  obj_rdata_q <= pos_ofs_q;
               `DSOO_IDX_VEL_OFS:  obj_rdata_q <= vel_ofs_q;
               `DSOO_IDX_TRQ_OFS:  obj_rdata_q <= {{16{trq_ofs_q[15]}},
                                                   trq_ofs_q};
               `DSOO_IDX_IP_SETPT: obj_rdata_q <= ip_pend_q;
               default:            obj_rdata_q <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

//--- common/dsoo_consts.vh
// object indices, field positions and preset values of the set-point block
// assumes a 16-bit object index and 32-bit data on the object access port
`ifndef DSOO_CONSTS_VH
`define DSOO_CONSTS_VH

// ====================================================================
// object indices
`define DSOO_IDX_VEL_UNIT    16'h60A9
`define DSOO_IDX_POS_OFS     16'h60B0
`define DSOO_IDX_VEL_OFS     16'h60B1
`define DSOO_IDX_TRQ_OFS     16'h60B2
`define DSOO_IDX_IP_SETPT    16'h60C1

// ====================================================================
// preset values
`define DSOO_RST_VEL_UNIT    32'h00B44700
`define DSOO_RST_POS_OFS     32'h00000000
`define DSOO_RST_VEL_OFS     32'h00000000
`define DSOO_RST_TRQ_OFS     16'h0000
`define DSOO_RST_IP_SETPT    32'h00000000

// ====================================================================
// velocity unit word fields
`define DSOO_VU_TIME_LSB     8
`define DSOO_VU_TIME_MSB     15
`define DSOO_VU_POS_LSB      16
`define DSOO_VU_POS_MSB      23
`define DSOO_VU_EXP_LSB      24
`define DSOO_VU_EXP_MSB      31
`define DSOO_VU_RSVD_MASK    32'h000000FF

// ====================================================================
// operating mode codes
`define DSOO_MODE_IP         8'h07
`define DSOO_MODE_CSP        8'h08
`define DSOO_MODE_CSV        8'h09
`define DSOO_MODE_CST        8'h0A
`define DSOO_MODE_CLKDIR     8'hFF

`endif

//--- testbench/dsoo_chk_asserts.sv
// port checker of the set-point object block
// assumes one clock domain with arst_n active low
`timescale 1ns/100ps
`include "dsoo_consts.vh"
// ====================================================
// checker
module dsoo_chk (
   input logic        clk,
   input logic        arst_n,
   input logic        clk_en,
   input logic        obj_wr,
   input logic        obj_rd,
   input logic [15:0] obj_index,
   input logic        sync_tick,
   input logic [7:0]  op_mode,
   input logic [31:0] pos_set_in,
   input logic [31:0] vel_set_in,
   input logic [15:0] trq_set_in,
   input logic [31:0] obj_rdata_q,
   input logic        obj_ack_q,
   input logic        obj_err_q,
   input logic [31:0] pos_set_out_q,
   input logic [31:0] vel_set_out_q,
   input logic [15:0] trq_set_out_q,
   input logic [31:0] ip_demand_q,
   input logic        ip_demand_vld_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // an access taken by the block
   sequence s_req;
      clk_en && (obj_wr || obj_rd);
   endsequence
   // a read of the unit word
   sequence s_vu_rd;
      clk_en && obj_rd && obj_index == `DSOO_IDX_VEL_UNIT;
   endsequence
   chk_one_answer: assert property (s_req |=> obj_ack_q != obj_err_q)
      else $error("access not answered once");
   chk_rdata_idle: assert property (!obj_ack_q |-> obj_rdata_q == 32'h0)
      else $error("read data outside answer");
   chk_rsvd_zero: assert property (s_vu_rd |=> obj_rdata_q[7:0] == 8'h0)
      else $error("reserved unit bits set");
   chk_pos_idle: assert property (
      clk_en && op_mode != `DSOO_MODE_CSP |=> pos_set_out_q == $past(pos_set_in))
      else $error("position offset applied");
   chk_vel_idle: assert property (clk_en && !(op_mode inside
      {`DSOO_MODE_CSP, `DSOO_MODE_CSV, `DSOO_MODE_CLKDIR})
      |=> vel_set_out_q == $past(vel_set_in)) else $error("velocity offset");
   chk_trq_idle: assert property (clk_en && !(op_mode inside
      {`DSOO_MODE_CSP, `DSOO_MODE_CST, `DSOO_MODE_CLKDIR})
      |=> trq_set_out_q == $past(trq_set_in)) else $error("torque offset");
   chk_ip_hold: assert property (!sync_tick |=> $stable(ip_demand_q))
      else $error("demand moved without sync");
   chk_ip_valid: assert property (clk_en |=>
      ip_demand_vld_q == ($past(op_mode) == `DSOO_MODE_IP))
      else $error("demand valid wrong");
endmodule
bind dsoo_setpoint_objects dsoo_chk dsoo_chk_i (.*);

//--- testbench/dsoo_master.sv
// fieldbus master model writing and reading objects
// assumes requests launch just after a rising clk edge
`timescale 1ns/100ps
// ====================================================
// master
module dsoo_master (
   input  logic        clk,
   input  logic [31:0] obj_rdata_q,
   input  logic        obj_err_q,
   output logic        obj_wr = 1'h0,
   output logic        obj_rd = 1'h0,
   output logic [15:0] obj_index = 16'h0,
   output logic [31:0] obj_wdata = 32'h0,
   output logic        sync_tick = 1'h0
);
   // one-cycle write; released bus shows inverted values
   task wr(input logic [15:0] i, input logic [31:0] d);
      @(posedge clk) {obj_wr, obj_index, obj_wdata} <= {1'h1, i, d};
      @(posedge clk) {obj_wr, obj_index, obj_wdata} <= {1'h0, ~i, ~d};
   endtask
   // one-cycle read; answer taken once it has settled
   task rd(input logic [15:0] i, output logic [32:0] r);
      @(posedge clk) {obj_rd, obj_index} <= {1'h1, i};
      @(posedge clk) {obj_rd, obj_index} <= {1'h0, ~i};
      #1 r = {obj_err_q, obj_rdata_q};
   endtask
   // one-cycle synchronization event
   task tick;
      @(posedge clk) sync_tick <= 1'h1;
      @(posedge clk) sync_tick <= 1'h0;
   endtask
endmodule

//--- testbench/dsoo_tb_top.sv
// self-checking bench of the set-point object block
// assumes master model and bound checker beside the design
`timescale 1ns/100ps
// ====================================================
// bench
module drive_setpoint_offset_objects_tb_top;
   logic clk = 1'h0, arst_n = 1'h0, clk_en = 1'h0;
   logic [7:0] op_mode = 8'h07;
   logic [31:0] pos_set_in = 32'h100, vel_set_in = 32'h200;
   logic [15:0] trq_set_in = 16'h300;
   wire obj_wr, obj_rd, sync_tick, obj_ack_q, obj_err_q, ip_demand_vld_q;
   wire [15:0] obj_index, trq_set_out_q;
   wire [31:0] obj_wdata, obj_rdata_q, pos_set_out_q, vel_set_out_q;
   wire [31:0] ip_demand_q;
   wire [7:0] vu_time_q, vu_pos_q, vu_exp_q;
   int error_cnt = 0, checks = 0;
   logic [32:0] r;
   // mode beside expected position, velocity and torque
   logic [87:0] rows [5] = '{{8'h07, 32'h100, 32'h200, 16'h300},
      {8'h08, 32'h110, 32'h220, 16'h2FE}, {8'h09, 32'h100, 32'h220, 16'h300},
      {8'h0A, 32'h100, 32'h200, 16'h2FE}, {8'hFF, 32'h100, 32'h220, 16'h2FE}};
   dsoo_setpoint_objects dsoo_setpoint_objects_i (.*);
   dsoo_master dsoo_master_i (.*);
   always #12.5 clk = ~clk;
   // compare and count
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      #50us error_cnt++;
      complete_run;
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      {arst_n, clk_en} <= 2'h3;
      chk({vu_exp_q, vu_pos_q, vu_time_q}, 33'hB447);
      dsoo_master_i.rd(16'h60A9, r);
      chk(r, 33'h00B44700);
      dsoo_master_i.wr(16'h60A9, 32'h12345678);
      dsoo_master_i.rd(16'h60A9, r);
      chk(r, 33'h12345600);
      chk({vu_exp_q, vu_pos_q, vu_time_q}, 33'h123456);
      dsoo_master_i.rd(16'h60AA, r);
      chk(r, 33'h100000000);
      $display("unit word test done");
      dsoo_master_i.wr(16'h60B0, 32'h10);
      dsoo_master_i.wr(16'h60B1, 32'h20);
      dsoo_master_i.wr(16'h60B2, 32'hFFFE);
      dsoo_master_i.rd(16'h60B2, r);
      chk(r, 33'hFFFFFFFE);
      for (int k = 0; k < 5; k++) begin
         @(posedge clk) op_mode <= rows[k][87:80];
         repeat (2) @(posedge clk);
         #1 chk(pos_set_out_q, rows[k][79:48]);
         chk(vel_set_out_q, rows[k][47:16]);
         chk(trq_set_out_q, rows[k][15:0]);
      end
      $display("offset test done");
      @(posedge clk) op_mode <= 8'h07;
      dsoo_master_i.wr(16'h60C1, 32'h55);
      repeat (3) @(posedge clk);
      #1 chk(ip_demand_q, 33'h0);
      dsoo_master_i.tick;
      #1 chk(ip_demand_q, 33'h55);
      chk(ip_demand_vld_q, 33'h1);
      // a write in the same cycle as sync waits for the following sync
      fork
         dsoo_master_i.wr(16'h60C1, 32'h77);
         dsoo_master_i.tick;
      join
      #1 chk(ip_demand_q, 33'h55);
      dsoo_master_i.tick;
      #1 chk(ip_demand_q, 33'h77);
      $display("interpolation test done");
      // low clock enable freezes the set outputs
      @(posedge clk) {clk_en, op_mode} <= {1'h0, 8'h08};
      repeat (3) @(posedge clk);
      #1 chk(pos_set_out_q, 33'h100);
      @(posedge clk) clk_en <= 1'h1;
      repeat (2) @(posedge clk);
      #1 chk(pos_set_out_q, 33'h110);
      $display("clock enable test done");
      // reset in mid-run brings back the preset values
      @(posedge clk) arst_n <= 1'h0;
      @(posedge clk);
      #1 chk({vu_exp_q, vu_pos_q, vu_time_q}, 33'hB447);
      chk(ip_demand_q, 33'h0);
      chk(pos_set_out_q, 33'h0);
      @(posedge clk) arst_n <= 1'h1;
      dsoo_master_i.rd(16'h60A9, r);
      chk(r, 33'h00B44700);
      dsoo_master_i.rd(16'h60C1, r);
      chk(r, 33'h0);
      $display("mid-run reset test done");
      complete_run;
   end
endmodule
